// [rtl/cisd_disp_ram.sv]
// Sixteen-digit display RAM with registered read data.
// Assumes the core clock and its clock enable.
`timescale 1ns/1ps
module cisd_disp_ram
    import cisd_pkg::*;
(
    // Clock and enable
    input wire logic i_core_clk,
    input wire logic i_ce,
    // RAM port
    cisd_ram_if.mem ram
);
    logic [7:0] mem [16];
    logic [7:0] rdata;

    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (ram.wr) begin
                mem[ram.waddr] <= ram.wdata;
            end
            rdata <= mem[ram.raddr];
        end
    end

    assign ram.rdata = rdata;
endmodule : cisd_disp_ram

// [rtl/cisd_top.sv]
// Processor-side strobe decoder, timing gate generator and counters.
// Assumes a plain one-cycle register port and asynchronous board inputs.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module cisd_top
    import cisd_pkg::*;
#(
    parameter int unsigned DISP_RST_CYC = DISP_RST_CYC_DEF
)
(
    // Clock, enable, reset
    input wire logic i_core_clk,
    input wire logic i_ce,
    input wire logic i_rst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Peripheral strobes
    output logic o_divisor_high_load_n,
    output logic o_divisor_low_load_n,
    output logic o_timing_write_n,
    output logic o_timing_read_n,
    output logic o_power_detect_read_n,
    output logic o_power_detect_write_n,
    output logic o_instrument_bus_select_n,
    output logic o_keypad_read_n,
    output logic o_counter_read_n,
    // Shared data bus
    output logic [7:0] o_bus_data,
    output logic o_bus_data_oe,
    input wire logic [7:0] i_bus_data,
    // Board inputs
    input wire logic [7:0] i_pd_data,
    input wire logic [7:0] i_keypad_data,
    input wire logic i_interrupt_request_n,
    input wire logic i_ref_1mhz,
    input wire logic i_count_pulse,
    input wire logic i_free_run_diag_n,
    input wire logic i_fm_mode_select_n,
    input wire logic i_ext_timebase_select_n,
    // Synthesizer and loop
    output logic [15:0] o_divisor,
    output logic o_loop_filter_wide,
    output logic o_measure_start,
    // Counting gates
    output logic o_if_count_gate_n,
    output logic o_oscillator_counter_select,
    output logic o_count_en_a,
    output logic o_count_en_b,
    output logic o_direct_count_gate_n,
    // Misc control
    output logic [15:0] o_free_run_addr,
    output logic o_long_gate,
    output logic o_timebase_ext_sel,
    output logic o_irq_pending,
    // Display
    output logic o_display_blank_reset_n,
    output logic o_display_ram_write,
    output logic o_fm_indicator,
    output logic [7:0] o_display_data,
    output logic [3:0] o_display_digit
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic [STB_W-1:0] cisd_decode(input logic [7:0] a, input logic wr,
                                                     input logic rd);
        logic [STB_W-1:0] s;
        s = '0;
        unique case (a)
            A_DIVH: s[S_DIVH] = wr;
            A_DIVL: s[S_DIVL] = wr;
            A_TIM: begin
                s[S_TIMW] = wr;
                s[S_TIMR] = rd;
            end
            A_PD: begin
                s[S_PDW] = wr;
                s[S_PDR] = rd;
            end
            A_KBD: s[S_KBD] = rd;
            A_CTRA, A_CTRB: s[S_CTR] = rd;
            A_IBUS: s[S_IBUS] = wr | rd;
            default: s = '0;
        endcase
        return s;
    endfunction : cisd_decode

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sy1;
    logic [SYNC_W-1:0] sy2;
    logic cnt_q;
    logic ref_q;

    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            sy1 <= {i_pd_data, i_keypad_data, i_bus_data, i_interrupt_request_n, i_ref_1mhz,
                    i_count_pulse, i_free_run_diag_n, i_fm_mode_select_n,
                    i_ext_timebase_select_n};
            sy2 <= sy1;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cisd_ram_if ram ();
    logic [STB_W-1:0] strb, next_strb;
    logic [7:0] bus_q, next_bus_q;
    logic [7:0] rdata, next_rdata;
    logic [15:0] divisor, next_divisor;
    logic [7:0] tim_ctl, next_tim_ctl;
    logic filt, next_filt;
    cisd_gate_t gate, next_gate;
    logic [13:0] gate_cnt, next_gate_cnt;
    logic [7:0] cnt_a, next_cnt_a;
    logic [7:0] cnt_b, next_cnt_b;
    logic [15:0] free_addr, next_free_addr;
    logic [15:0] rst_cnt, next_rst_cnt;
    logic blank_n, next_blank_n;
    logic dsp_wr, next_dsp_wr;
    logic [3:0] scan, next_scan;
    logic [3:0] digit, next_digit;
    logic [7:0] disp, next_disp;
    logic next_cnt_q;
    logic next_ref_q;
    logic if_on;
    logic dir_on;

    assign if_on = (gate == GT_RUN) && !tim_ctl[TIM_DIRECT];
    assign dir_on = (gate == GT_RUN) && tim_ctl[TIM_DIRECT];

    always_comb begin
        next_strb = cisd_decode(i_addr, i_wr, i_rd);
        next_bus_q = i_wr ? i_wdata : bus_q;
        next_rdata = 8'h00;
        next_divisor = divisor;
        next_tim_ctl = tim_ctl;
        next_filt = filt;
        next_gate = gate;
        next_gate_cnt = gate_cnt;
        next_cnt_a = cnt_a;
        next_cnt_b = cnt_b;
        next_free_addr = free_addr;
        next_rst_cnt = rst_cnt;
        next_blank_n = blank_n;
        next_dsp_wr = dsp_wr;
        next_scan = scan;
        next_digit = scan;
        next_disp = 8'h00;
        next_cnt_q = sy2[SY_CNT];
        next_ref_q = sy2[SY_REF];
        // Captures at the strobe's rising edge
        if (strb[S_DIVH]) begin
            next_divisor[15:8] = bus_q;
        end
        if (strb[S_DIVL]) begin
            next_divisor[7:0] = bus_q;
        end
        if (strb[S_PDW]) begin
            next_filt = bus_q[0];
        end
        if (strb[S_TIMW]) begin
            next_tim_ctl = bus_q;
        end
        if (i_rd) begin
            unique case (i_addr)
                A_TIM: next_rdata = {5'h00, gate == GT_RUN, tim_ctl[TIM_DIRECT],
                                     tim_ctl[TIM_OSC_SEL]};
                A_PD: next_rdata = sy2[SY_PD +: 8];
                A_KBD: next_rdata = sy2[SY_KBD +: 8];
                A_CTRA, A_CTRB: next_rdata = i_addr[0] ? cnt_b : cnt_a;
                A_IBUS: next_rdata = sy2[SY_BUS +: 8];
                A_DSP: next_rdata = {7'h00, dsp_wr};
                A_STAT: next_rdata = {3'h0, !sy2[SY_IRQ], !sy2[SY_FR], !sy2[SY_FM],
                                      !sy2[SY_EXT], blank_n};
                default: next_rdata = 8'h00;
            endcase
        end
        if (i_wr && i_addr == A_DSP) begin
            next_dsp_wr = i_wdata[DSP_WRITE];
        end
        // Gate period generator, 1 MHz ticks
        unique case (gate)
            GT_IDLE: begin
                if (strb[S_TIMW] && bus_q[TIM_START]) begin
                    next_gate = GT_RUN;
                    next_gate_cnt = sy2[SY_FM] ? GATE_SHORT_US : GATE_LONG_US;
                end
            end
            GT_RUN: begin
                if (sy2[SY_REF] && !ref_q) begin
                    next_gate_cnt = gate_cnt - 14'h0001;
                    if (gate_cnt == 14'h0001) begin
                        next_gate = GT_IDLE;
                    end
                end
            end
        endcase
        if (if_on && sy2[SY_CNT] && !cnt_q) begin
            if (tim_ctl[TIM_OSC_SEL]) begin
                next_cnt_b = cnt_b + 8'h01;
            end else begin
                next_cnt_a = cnt_a + 8'h01;
            end
        end
        if (!sy2[SY_FR]) begin
            next_free_addr = free_addr + 16'h0001;
        end
        if (!blank_n) begin
            next_rst_cnt = rst_cnt + 16'h0001;
            if (rst_cnt == 16'(DISP_RST_CYC - 1)) begin
                next_blank_n = 1'b1;
            end
        end
        if (!dsp_wr) begin
            next_scan = scan + 4'h1;
            if (blank_n) begin
                next_disp = ram.rdata;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            strb <= '0;
            bus_q <= 8'h00;
            rdata <= 8'h00;
            divisor <= DIV_RST;
            tim_ctl <= TIM_RST;
            filt <= 1'b0;
            gate <= GT_IDLE;
            gate_cnt <= 14'h0000;
            cnt_a <= 8'h00;
            cnt_b <= 8'h00;
            free_addr <= 16'h0000;
            rst_cnt <= 16'h0000;
            blank_n <= 1'b0;
            dsp_wr <= 1'b0;
            scan <= 4'h0;
            digit <= 4'h0;
            disp <= 8'h00;
            cnt_q <= 1'b0;
            ref_q <= 1'b0;
        end else if (i_ce) begin
            strb <= next_strb;
            bus_q <= next_bus_q;
            rdata <= next_rdata;
            divisor <= next_divisor;
            tim_ctl <= next_tim_ctl;
            filt <= next_filt;
            gate <= next_gate;
            gate_cnt <= next_gate_cnt;
            cnt_a <= next_cnt_a;
            cnt_b <= next_cnt_b;
            free_addr <= next_free_addr;
            rst_cnt <= next_rst_cnt;
            blank_n <= next_blank_n;
            dsp_wr <= next_dsp_wr;
            scan <= next_scan;
            digit <= next_digit;
            disp <= next_disp;
            cnt_q <= next_cnt_q;
            ref_q <= next_ref_q;
        end
    end

    // ------------------------------------------------------------
    // Display RAM
    // ------------------------------------------------------------
    assign ram.wr = i_wr && (i_addr[7:4] == A_RAM_PAGE) && dsp_wr;
    assign ram.waddr = i_addr[3:0];
    assign ram.wdata = i_wdata;
    assign ram.raddr = scan;

    cisd_disp_ram u_ram (
        .i_core_clk(i_core_clk),
        .i_ce(i_ce),
        .ram(ram)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata;
    assign o_divisor_high_load_n = !strb[S_DIVH];
    assign o_divisor_low_load_n = !strb[S_DIVL];
    assign o_timing_write_n = !strb[S_TIMW];
    assign o_timing_read_n = !strb[S_TIMR];
    assign o_power_detect_read_n = !strb[S_PDR];
    assign o_power_detect_write_n = !strb[S_PDW];
    assign o_instrument_bus_select_n = !strb[S_IBUS];
    assign o_keypad_read_n = !strb[S_KBD];
    assign o_counter_read_n = !strb[S_CTR];
    assign o_bus_data = bus_q;
    // Instrument-bus accesses leave the shared bus to the option board
    assign o_bus_data_oe = strb[S_DIVH] | strb[S_DIVL] | strb[S_TIMW] | strb[S_PDW];
    assign o_divisor = divisor;
    assign o_loop_filter_wide = filt;
    assign o_measure_start = strb[S_PDW];
    assign o_if_count_gate_n = !if_on;
    assign o_oscillator_counter_select = tim_ctl[TIM_OSC_SEL];
    assign o_count_en_a = if_on && !tim_ctl[TIM_OSC_SEL];
    assign o_count_en_b = if_on && tim_ctl[TIM_OSC_SEL];
    assign o_direct_count_gate_n = !dir_on;
    assign o_free_run_addr = free_addr;
    assign o_long_gate = !sy2[SY_FM];
    assign o_fm_indicator = !sy2[SY_FM];
    assign o_timebase_ext_sel = !sy2[SY_EXT];
    assign o_irq_pending = !sy2[SY_IRQ];
    assign o_display_blank_reset_n = blank_n;
    assign o_display_ram_write = dsp_wr;
    assign o_display_data = disp;
    assign o_display_digit = digit;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_divh;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !o_divisor_high_load_n) |=> (o_divisor[15:8] == $past(o_bus_data));
    endproperty
    a_divh: assert property (p_divh) else $error("divisor high not captured");

    property p_divl;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !o_divisor_low_load_n) |=> (o_divisor[7:0] == $past(o_bus_data));
    endproperty
    a_divl: assert property (p_divl) else $error("divisor low not captured");

    property p_timw;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !o_timing_write_n) |=> (o_oscillator_counter_select == $past(o_bus_data[0]));
    endproperty
    a_timw: assert property (p_timw) else $error("timing register not loaded");

    property p_timr;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && i_addr == A_TIM) |=> !o_timing_read_n;
    endproperty
    a_timr: assert property (p_timr) else $error("timing read strobe missing");

    property p_meas;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_measure_start == !o_power_detect_write_n;
    endproperty
    a_meas: assert property (p_meas) else $error("measure not tied to strobe");

    property p_filt;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !o_power_detect_write_n) |=> (o_loop_filter_wide == $past(o_bus_data[0]));
    endproperty
    a_filt: assert property (p_filt) else $error("loop filter select wrong");

    property p_onehot;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $onehot0(strb);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two strobes at once");

    property p_blank;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !o_display_blank_reset_n |-> (o_display_data == 8'h00);
    endproperty
    a_blank: assert property (p_blank) else $error("display lit during reset");

    property p_ctr_sel;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_count_en_b |-> (!o_if_count_gate_n && o_oscillator_counter_select && !o_count_en_a);
    endproperty
    a_ctr_sel: assert property (p_ctr_sel) else $error("counter select mismatch");

    property p_free;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !sy2[SY_FR]) |=> (o_free_run_addr == 16'($past(o_free_run_addr) + 16'h0001));
    endproperty
    a_free: assert property (p_free) else $error("free run address not stepping");
endmodule : cisd_top

// [shared/cisd_pkg.sv]
// Constants, address map and types of the counter strobe decoder.
// Assumes one 125 MHz core clock; peripheral inputs arrive asynchronously.
package cisd_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned DISP_RST_US = 100;
    localparam int unsigned DISP_RST_CYC_DEF = DISP_RST_US * CLK_MHZ;
    localparam logic [13:0] GATE_SHORT_US = 14'h03e8;
    localparam logic [13:0] GATE_LONG_US = 14'h2710;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0] A_DIVH = 8'h00;
    localparam logic [7:0] A_DIVL = 8'h01;
    localparam logic [7:0] A_TIM = 8'h02;
    localparam logic [7:0] A_PD = 8'h03;
    localparam logic [7:0] A_KBD = 8'h04;
    localparam logic [7:0] A_CTRA = 8'h06;
    localparam logic [7:0] A_CTRB = 8'h07;
    localparam logic [7:0] A_IBUS = 8'h08;
    localparam logic [7:0] A_DSP = 8'h09;
    localparam logic [7:0] A_STAT = 8'h0a;
    localparam logic [3:0] A_RAM_PAGE = 4'h1;
    // ------------------------------------------------------------
    // Strobe positions
    // ------------------------------------------------------------
    localparam int unsigned STB_W = 9;
    localparam int unsigned S_DIVH = 0;
    localparam int unsigned S_DIVL = 1;
    localparam int unsigned S_TIMW = 2;
    localparam int unsigned S_TIMR = 3;
    localparam int unsigned S_PDR = 4;
    localparam int unsigned S_PDW = 5;
    localparam int unsigned S_IBUS = 6;
    localparam int unsigned S_KBD = 7;
    localparam int unsigned S_CTR = 8;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned TIM_OSC_SEL = 0;
    localparam int unsigned TIM_START = 1;
    localparam int unsigned TIM_DIRECT = 2;
    localparam int unsigned DSP_WRITE = 0;
    localparam logic [7:0] TIM_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;
    // ------------------------------------------------------------
    // Synchroniser vector layout
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = 30;
    localparam int unsigned SY_EXT = 0;
    localparam int unsigned SY_FM = 1;
    localparam int unsigned SY_FR = 2;
    localparam int unsigned SY_CNT = 3;
    localparam int unsigned SY_REF = 4;
    localparam int unsigned SY_IRQ = 5;
    localparam int unsigned SY_BUS = 6;
    localparam int unsigned SY_KBD = 14;
    localparam int unsigned SY_PD = 22;

    typedef enum logic {
        GT_IDLE = 1'b0,
        GT_RUN = 1'b1
    } cisd_gate_t;
endpackage : cisd_pkg

// [shared/cisd_ram_if.sv]
// Display RAM port between the decoder and its memory.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface cisd_ram_if;
    logic wr;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output wr, output waddr, output wdata, output raddr, input rdata);
    modport mem (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface : cisd_ram_if

// [test/cisd_periph_model.sv]
// Model of the peripheral boards facing the strobe decoder.
// Assumes the bench core clock; the 1 MHz reference is scaled to 8 core cycles.
`timescale 1ns/1ps
module cisd_periph_model
#(
    parameter logic [7:0] PD_VAL = 8'h6b,
    parameter logic [7:0] KBD_VAL = 8'h92
)
(
    // Clock and bench control
    input wire logic i_core_clk,
    input wire logic i_irq_req,
    // Strobes from the decoder
    input wire logic i_timing_read_n,
    // Board outputs
    output logic [7:0] o_bus_data,
    output logic [7:0] o_pd_data,
    output logic [7:0] o_keypad_data,
    output logic o_interrupt_request_n,
    output logic o_ref_1mhz,
    output logic o_count_pulse
);
    logic [3:0] div_cnt = 4'h0;
    logic [7:0] bus_q = 8'h00;

    always @(posedge i_core_clk) begin
        div_cnt <= div_cnt + 4'h1;
        // Released bus toggles so a stale value never passes
        bus_q <= i_timing_read_n ? ~bus_q : 8'h5a;
    end
    assign o_ref_1mhz = div_cnt[2];
    assign o_count_pulse = div_cnt[0];
    assign o_bus_data = bus_q;
    assign o_pd_data = PD_VAL;
    assign o_keypad_data = KBD_VAL;
    assign o_interrupt_request_n = ~i_irq_req;
endmodule : cisd_periph_model

// [test/counter_io_strobe_decode_bench.sv]
// Self-checking bench for the strobe decoder over its register port.
// Assumes the peripheral model on the board side and a 20-cycle blank time.
`timescale 1ns/1ps
module counter_io_strobe_decode_bench;
    import cisd_pkg::*;
    localparam logic [7:0] PD = 8'h6b;
    localparam logic [7:0] KB = 8'h92;
    logic clk, rst_n, wr, rd, fr_n, fm_n, ext_n, irq_req;
    logic [7:0] addr, wdata, rdata, bus_d, pd_d, kb_d, bd;
    logic oe;
    logic irq_n, ref1, cnt_p, if_n, sel, en_a, en_b, dir_n, long_g, ext_s, irq_p;
    logic blank_n, ram_w, fm_i, mst, filt;
    logic [15:0] divisor, fr_addr, a0;
    wire [8:0] stb;
    int err_count, compares, n;

    cisd_top #(.DISP_RST_CYC(20)) u_cisd_top (.i_core_clk(clk), .i_ce(1'b1), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_divisor_high_load_n(stb[S_DIVH]), .o_divisor_low_load_n(stb[S_DIVL]),
        .o_timing_write_n(stb[S_TIMW]), .o_timing_read_n(stb[S_TIMR]),
        .o_power_detect_read_n(stb[S_PDR]), .o_power_detect_write_n(stb[S_PDW]),
        .o_instrument_bus_select_n(stb[S_IBUS]), .o_keypad_read_n(stb[S_KBD]),
        .o_counter_read_n(stb[S_CTR]), .o_bus_data(bd), .o_bus_data_oe(oe), .i_bus_data(bus_d),
        .i_pd_data(pd_d), .i_keypad_data(kb_d), .i_interrupt_request_n(irq_n),
        .i_ref_1mhz(ref1), .i_count_pulse(cnt_p), .i_free_run_diag_n(fr_n),
        .i_fm_mode_select_n(fm_n), .i_ext_timebase_select_n(ext_n), .o_divisor(divisor),
        .o_loop_filter_wide(filt), .o_measure_start(mst), .o_if_count_gate_n(if_n),
        .o_oscillator_counter_select(sel), .o_count_en_a(en_a), .o_count_en_b(en_b),
        .o_direct_count_gate_n(dir_n), .o_free_run_addr(fr_addr), .o_long_gate(long_g),
        .o_timebase_ext_sel(ext_s), .o_irq_pending(irq_p), .o_display_blank_reset_n(blank_n),
        .o_display_ram_write(ram_w), .o_fm_indicator(fm_i), .o_display_data(),
        .o_display_digit());

    cisd_periph_model #(.PD_VAL(PD), .KBD_VAL(KB)) u_cisd_periph_model (.i_core_clk(clk),
        .i_irq_req(irq_req), .i_timing_read_n(stb[S_TIMR]), .o_bus_data(bus_d),
        .o_pd_data(pd_d), .o_keypad_data(kb_d), .o_interrupt_request_n(irq_n),
        .o_ref_1mhz(ref1), .o_count_pulse(cnt_p));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // One write or read; checks which strobe pulses in the answer cycle
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input int s);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        check({7'h0, stb}, (s < 0) ? 16'h01ff : {7'h0, ~(9'h1 << s)}, "strobe");
        check({7'h0, oe, w ? bd : d}, {7'h0, w && s >= 0 && s != S_IBUS, d}, "bus drive");
    endtask : access

    task automatic wait_low_end(input logic dir);
        n = 0;
        while ((dir ? dir_n : if_n) === 1'b0 && n < 12000) begin
            @(posedge clk);
            n++;
        end
        check(16'(n > 7900 && n < 8100), 16'h1, "gate length");
        if (n >= 12000)
            test_done();
    endtask : wait_low_end

    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, wr, rd, irq_req} = 4'h0;
        {fr_n, fm_n, ext_n} = 3'h7;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        check({7'h0, stb}, 16'h01ff, "reset strobes");
        check({7'h0, blank_n, rdata}, 16'h0000, "reset state");
        check(divisor, DIV_RST, "divisor reset");
        rst_n <= 1'b1;
        repeat (18) @(posedge clk);
        check(16'(blank_n), 16'h0, "blank held");
        repeat (4) @(posedge clk);
        check(16'(blank_n), 16'h1, "blank released");
        access(1'b1, A_DIVH, 8'ha5, S_DIVH);
        access(1'b1, A_DIVL, 8'h3c, S_DIVL);
        #8;
        check(divisor, 16'ha53c, "divisor");
        access(1'b1, A_TIM, 8'h01, S_TIMW);
        #16;
        check(16'(sel), 16'h1, "osc select");
        access(1'b0, A_TIM, 8'h00, S_TIMR);
        check(16'(rdata), 16'h0001, "timing data");
        access(1'b0, A_PD, 8'h00, S_PDR);
        check(16'(rdata), 16'(PD), "detector data");
        access(1'b0, A_KBD, 8'h00, S_KBD);
        check(16'(rdata), 16'(KB), "keypad data");
        access(1'b0, A_CTRA, 8'h00, S_CTR);
        check(16'(rdata), 16'h0, "counter a idle");
        access(1'b0, A_CTRB, 8'h00, S_CTR);
        check(16'(rdata), 16'h0, "counter b idle");
        access(1'b0, 8'h05, 8'h00, -1);
        check(16'(rdata), 16'h0, "unmapped read");
        access(1'b1, A_IBUS, 8'h11, S_IBUS);
        access(1'b0, A_IBUS, 8'h00, S_IBUS);
        for (int i = 1; i >= 0; i--) begin
            access(1'b1, A_PD, 8'(i), S_PDW);
            check(16'(mst), 16'h1, "measure start");
            #8;
            check(16'(filt), 16'(i), "loop filter");
        end
        for (int i = 1; i >= 0; i--) begin
            access(1'b1, A_DSP, 8'(i), -1);
            #8;
            check(16'(ram_w), 16'(i), "display write");
        end
        fr_n <= 1'b0;
        fm_n <= 1'b0;
        ext_n <= 1'b0;
        irq_req <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({long_g, fm_i, ext_s, irq_p}, 16'hf, "board inputs");
        a0 = fr_addr;
        repeat (8) @(posedge clk);
        #1;
        check(fr_addr, a0 + 16'h8, "free run step");
        {fr_n, fm_n, ext_n} <= 3'h7;
        irq_req <= 1'b0;
        access(1'b1, A_TIM, 8'h02, S_TIMW);
        repeat (4) @(posedge clk);
        #1;
        check({if_n, dir_n, sel, en_a, en_b}, 16'h0a, "if gate open");
        wait_low_end(1'b0);
        access(1'b1, A_TIM, 8'h06, S_TIMW);
        repeat (4) @(posedge clk);
        #1;
        check({if_n, dir_n}, 16'h2, "direct gate open");
        wait_low_end(1'b1);
        test_done();
    end
endmodule : counter_io_strobe_decode_bench
